// >>> tb/bax_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Data memory behind the core.
module bax_mem_model (
  input  wire logic       clk,
  input  wire logic [8:0] mem_addr,
  input  wire logic       mem_rd,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] register_operand
);
  logic [7:0] mem [512];

  initial begin
    register_operand = 8'h3c;
  end

  // A read answers for one cycle only; otherwise the bus toggles so stale data never passes.
  always @(posedge clk) begin
    if (mem_rd) begin
      register_operand <= mem[mem_addr];
    end else begin
      register_operand <= ~register_operand;
    end
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

`default_nettype wire

// >>> tb/byte_alu_subc_swap_test_xor_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module byte_alu_subc_swap_test_xor_tb_top import bax_pkg::*;;
  // Row: opcode, operand, accumulator, write data, {c,nb,z,we}, {pad,illegal,timer}.
  typedef struct packed {
    logic [15:0] op;
    logic [7:0]  opnd;
    logic [7:0]  acc;
    logic [7:0]  wd;
    logic        c;
    logic        nb;
    logic        z;
    logic        we;
    logic [1:0]  pad;
    logic        ill;
    logic        tm;
  } bax_row_type;

  logic        clk;
  logic        rst;
  logic        instr_valid;
  logic [15:0] opcode;
  logic        instr_ready;
  logic        instr_done;
  logic        illegal_opcode;
  logic [8:0]  mem_addr;
  logic        mem_rd;
  logic [7:0]  register_operand;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  acc_out;
  logic        borrow_flag;
  logic        nibble_borrow_flag;
  logic        zero_flag;
  logic        tmr_prescaler_clear;
  logic        tmr_count_hold;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          n_compared;
  int          k;

  // Each row follows on from the accumulator and flags left by the row above.
  bax_row_type rows [17] = '{
    48'h7f51_00_51_00_0_0, 48'h1899_51_00_00_2_0, 48'h7f0f_00_0f_00_0_0,
    48'h7f09_00_06_00_0_0, 48'h4935_35_2e_00_8_0, 48'h4899_2e_00_00_e_0,
    48'h4810_10_10_00_c_0, 48'h4811_05_f5_00_4_0, 48'h4812_f5_ff_00_0_0,
    48'h3899_a5_5a_00_0_0, 48'h3a99_a5_5a_5a_1_0, 48'h2277_00_5a_00_3_0,
    48'h2201_80_5a_80_1_1, 48'h1b23_5a_5a_00_3_0, 48'h1a40_0f_5a_55_1_0,
    48'h1901_5a_00_00_2_0, 48'h0000_33_00_00_2_2};

  bax_core i_dut (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .opcode(opcode),
    .instr_ready(instr_ready), .instr_done(instr_done), .illegal_opcode(illegal_opcode),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .register_operand(register_operand),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .acc_out(acc_out), .borrow_flag(borrow_flag),
    .nibble_borrow_flag(nibble_borrow_flag), .zero_flag(zero_flag),
    .tmr_prescaler_clear(tmr_prescaler_clear), .tmr_count_hold(tmr_count_hold),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  bax_mem_model i_mem (
    .clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .register_operand(register_operand));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Offers one opcode, waits for the accept edge, then checks the finishing cycle.
  task automatic do_row(input bax_row_type r);
    int n;
    i_mem.mem[r.op[8:0]] = r.opnd;
    instr_valid <= 1'b1;
    opcode      <= r.op;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 50);
    if (instr_ready !== 1'b1) begin
      fail_count++;
    end
    instr_valid <= 1'b0;
    // Outputs are read at the edge itself, so they show the cycle that this edge closes.
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_done !== 1'b1 && n < 50);
    chk(n, 3);
    chk(mem_addr, r.op[8:0]);
    chk(acc_out, r.acc);
    chk({borrow_flag, nibble_borrow_flag, zero_flag}, {r.c, r.nb, r.z});
    chk(mem_we, r.we);
    if (r.we) chk(mem_wdata, r.wd);
    chk(illegal_opcode, r.ill);
    chk({tmr_prescaler_clear, tmr_count_hold}, {r.tm, r.tm});
  endtask

  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The whole run needs well under a thousand cycles, so this only cuts a hang.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    fail_count = 0;
    n_compared = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    opcode = 16'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk({acc_out, borrow_flag, nibble_borrow_flag, zero_flag}, 11'h000);
    apb(1'b0, BAX_OFF_CTRL, 32'h0);
    chk(rd, 32'h0001_0001);
    $display("reset test done");
    for (k = 0; k < 17; k++) begin
      do_row(rows[k]);
      $display("row %0d done", k);
    end
    // Unmapped place answers with an error and zero data.
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, BAX_OFF_STATE, 32'hffff_ffff);
    apb(1'b0, BAX_OFF_STATE, 32'h0);
    chk(rd, 32'h0000_0400);
    // Seventeen rows have run, the foreign opcode among them.
    apb(1'b0, BAX_OFF_COUNT, 32'h0);
    chk(rd, 32'h0000_0011);
    $display("register test done");
    // Moving the timer address moves the prescaler clear with it.
    apb(1'b1, BAX_OFF_CTRL, 32'h0123_0001);
    do_row(48'h2323_01_00_01_1_1);
    do_row(48'h2201_00_00_00_3_0);
    $display("timer test done");
    // A disabled core must not take an offered opcode.
    apb(1'b1, BAX_OFF_CTRL, 32'h0123_0000);
    // Ready follows the enable bit one edge late, so the offer waits for that edge.
    @(posedge clk);
    instr_valid <= 1'b1;
    opcode      <= 16'h7f0f;
    k = 0;
    repeat (8) begin
      @(posedge clk);
      k += int'(instr_done === 1'b1);
    end
    instr_valid <= 1'b0;
    chk(k, 0);
    // Only the two timer rows may have been added; the offer made while disabled adds none.
    apb(1'b0, BAX_OFF_COUNT, 32'h0);
    chk(rd, 32'h0000_0013);
    apb(1'b1, BAX_OFF_CTRL, 32'h0123_0001);
    do_row(48'h7f0f_00_0f_00_0_0);
    $display("enable test done");
    // Reset in mid-run clears the accumulator and flags.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({acc_out, borrow_flag, nibble_borrow_flag, zero_flag}, 11'h000);
    repeat (2) @(posedge clk);
    do_row(48'h7f3c_00_3c_00_0_0);
    $display("second reset test done");
    report_and_stop();
  end
endmodule

`default_nettype wire

// >>> verilog/bax_alu.sv
`timescale 1ns/100ps
`default_nettype none

module bax_alu
  import bax_pkg::*;
(
  input  wire bax_op_type op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] imm,
  input  wire logic       c_in,
  input  wire logic       nb_in,
  input  wire logic       z_in,
  output logic [7:0]      result,
  output logic            c_out,
  output logic            nb_out,
  output logic            z_out,
  output logic            wr_mem,
  output logic            wr_acc
);

  // ==========================================================================
  // Result steering and flag update.
  // Both subtractions run on zero-extended operands so the top bit is the borrow.
  always_comb begin
    logic [8:0] diff;
    logic [4:0] low;
    diff   = 9'h000;
    low    = 5'h00;
    result = operand;
    c_out  = c_in;
    nb_out = nb_in;
    z_out  = z_in;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    diff = {1'b0, operand} - {1'b0, acc} - {8'h00, ~c_in}; // RULE2
    low  = {1'b0, operand[3:0]} - {1'b0, acc[3:0]} - {4'h0, ~c_in};
    case (op)
      BAX_OP_SUBC_W: begin
        result = diff[7:0]; // RULE1
        wr_acc = 1'b1;
        c_out  = ~diff[8]; // RULE3
        nb_out = ~low[4]; // RULE4
        z_out  = (diff[7:0] == 8'h00); // RULE5
      end
      BAX_OP_SWAP_F: begin
        result = {operand[3:0], operand[7:4]}; // RULE6
        wr_mem = 1'b1;
      end
      BAX_OP_SWAP_W: begin
        result = {operand[3:0], operand[7:4]}; // RULE7
        wr_acc = 1'b1;
      end
      BAX_OP_TEST_F: begin
        result = operand; // RULE8
        wr_mem = 1'b1;
        z_out  = (operand == 8'h00);
      end
      BAX_OP_XOR_F: begin
        result = operand ^ acc; // RULE11
        wr_mem = 1'b1;
        z_out  = (result == 8'h00); // RULE14
      end
      BAX_OP_XOR_W: begin
        result = acc ^ operand; // RULE12
        wr_acc = 1'b1;
        z_out  = (result == 8'h00); // RULE14
      end
      BAX_OP_XOR_K: begin
        result = acc ^ imm; // RULE13
        wr_acc = 1'b1;
        z_out  = (result == 8'h00); // RULE14
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> verilog/bax_core.sv
// Function
// [RULE1] Subtract-with-borrow: accumulator gets operand minus accumulator minus inverted borrow.
// [RULE2] Subtract-with-borrow treats both operands as unsigned bytes.
// [RULE3] Borrow flag clears on a negative difference, sets otherwise.
// [RULE4] Nibble-borrow flag clears on a borrow from bit 3 into bit 4.
// [RULE5] Zero flag sets when the subtraction result byte is zero.
// [RULE6] In-place nibble swap writes swapped byte back, flags untouched.
// [RULE7] Accumulator nibble swap loads swapped byte into accumulator, register kept.
// [RULE8] Register test writes value back unchanged and sets zero flag only.
// [RULE9] Testing the first timer count register clears that timer's prescaler.
// [RULE10] A test of the timer count blocks a coincident timer increment.
// [RULE11] Register XOR stores register XOR accumulator back into the register.
// [RULE12] Accumulator XOR puts accumulator XOR register into the accumulator.
// [RULE13] Immediate XOR combines accumulator with the low opcode byte.
// [RULE14] Every XOR form sets zero flag exactly when result is zero.
// [RULE15] Each instruction completes before the next one is accepted.
// [RULE16] The data address is taken from the nine low opcode bits.
`timescale 1ns/100ps
`default_nettype none

module bax_core
  import bax_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] opcode,
  output logic             instr_ready,
  output logic             instr_done,
  output logic             illegal_opcode,
  output logic [8:0]       mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  register_operand,
  output logic             mem_we,
  output logic [7:0]       mem_wdata,
  output logic [7:0]       acc_out,
  output logic             borrow_flag,
  output logic             nibble_borrow_flag,
  output logic             zero_flag,
  output logic             tmr_prescaler_clear,
  output logic             tmr_count_hold,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ==========================================================================
  // State of the whole block.
  typedef struct packed {
    bax_state_type st;
    bax_op_type    op;
    logic [8:0]    addr;
    logic [7:0]    imm;
    logic [7:0]    acc;
    logic          c;
    logic          nb;
    logic          z;
    logic          ready;
    logic          done;
    logic          bad_op;
    logic          mem_rd;
    logic          mem_we;
    logic [7:0]    wdata;
    logic          tmr_clr;
    logic          tmr_hold;
    logic          enable;
    logic [8:0]    tmr_addr;
    logic [15:0]   count;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } bax_core_type;

  localparam bax_core_type BAX_CORE_RST = '{
    st: BAX_IDLE, op: BAX_OP_NONE, addr: 9'h000, imm: 8'h00,
    acc: BAX_RST_ACC, c: 1'b0, nb: 1'b0, z: 1'b0, ready: 1'b0,
    done: 1'b0, bad_op: 1'b0, mem_rd: 1'b0, mem_we: 1'b0,
    wdata: 8'h00, tmr_clr: 1'b0, tmr_hold: 1'b0, enable: BAX_RST_EN,
    tmr_addr: BAX_RST_TADDR, count: 16'h0000, pready: 1'b0,
    pslverr: 1'b0, prdata: 32'h0000_0000
  };

  bax_core_type s_q;
  bax_core_type s_d;

  logic [7:0] alu_result;
  logic       alu_c;
  logic       alu_nb;
  logic       alu_z;
  logic       alu_wr_mem;
  logic       alu_wr_acc;

  // ==========================================================================
  // Datapath.
  // The operand is sampled only in the execute cycle, so the ALU looks at it live.
  bax_alu u_alu (
    .op      (s_q.op),
    .acc     (s_q.acc),
    .operand (register_operand),
    .imm     (s_q.imm),
    .c_in    (s_q.c),
    .nb_in   (s_q.nb),
    .z_in    (s_q.z),
    .result  (alu_result),
    .c_out   (alu_c),
    .nb_out  (alu_nb),
    .z_out   (alu_z),
    .wr_mem  (alu_wr_mem),
    .wr_acc  (alu_wr_acc)
  );

  // ==========================================================================
  // Sequencer and register slave.
  always_comb begin
    logic access;
    access     = psel && penable;
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.mem_rd = 1'b0;
    s_d.mem_we = 1'b0;
    s_d.tmr_clr  = 1'b0;
    s_d.tmr_hold = 1'b0;
    s_d.bad_op   = 1'b0;
    case (s_q.st)
      BAX_IDLE: begin
        s_d.ready = s_q.enable;
        if (instr_valid && s_q.ready) begin
          s_d.op     = bax_decode(opcode);
          s_d.addr   = opcode[BAX_ADDR_W-1:0]; // RULE16
          s_d.imm    = opcode[7:0];
          s_d.mem_rd = 1'b1;
          s_d.ready  = 1'b0;
          s_d.st     = BAX_FETCH;
        end
      end
      BAX_FETCH: begin
        s_d.st = BAX_EXEC;
      end
      BAX_EXEC: begin
        // Everything lands at one edge so the next instruction sees it all.
        s_d.st     = BAX_IDLE; // RULE15
        s_d.done   = 1'b1;
        s_d.bad_op = (s_q.op == BAX_OP_NONE);
        s_d.mem_we = alu_wr_mem;
        s_d.wdata  = alu_result;
        s_d.c      = alu_c;
        s_d.nb     = alu_nb;
        s_d.z      = alu_z;
        s_d.count  = s_q.count + 16'h0001;
        if (alu_wr_acc) begin
          s_d.acc = alu_result;
        end
        // Clear and hold go out together; the timer must drop any increment then.
        if (s_q.op == BAX_OP_TEST_F && s_q.addr == s_q.tmr_addr) begin
          s_d.tmr_clr  = 1'b1; // RULE9
          s_d.tmr_hold = 1'b1; // RULE10
        end
      end
      default: begin
        s_d.st = BAX_IDLE;
      end
    endcase
    // One wait state: the answer is prepared at the first access edge.
    s_d.pready = access && !s_q.pready;
    if (access && !s_q.pready) begin
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (paddr == BAX_OFF_CTRL) begin
        s_d.prdata[BAX_CTRL_EN] = s_q.enable;
        s_d.prdata[BAX_CTRL_TA +: 9] = s_q.tmr_addr;
      end else if (paddr == BAX_OFF_STATE) begin
        s_d.prdata[7:0] = s_q.acc;
        s_d.prdata[BAX_STATE_C]    = s_q.c;
        s_d.prdata[BAX_STATE_NB]   = s_q.nb;
        s_d.prdata[BAX_STATE_Z]    = s_q.z;
        s_d.prdata[BAX_STATE_BUSY] = (s_q.st != BAX_IDLE);
      end else if (paddr == BAX_OFF_COUNT) begin
        s_d.prdata[15:0] = s_q.count;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    // A write takes effect only at the edge where the master sees pready.
    if (access && s_q.pready && pwrite && paddr == BAX_OFF_CTRL) begin
      s_d.enable   = pwdata[BAX_CTRL_EN];
      s_d.tmr_addr = pwdata[BAX_CTRL_TA +: 9];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= BAX_CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register.
  assign instr_ready         = s_q.ready;
  assign instr_done          = s_q.done;
  assign illegal_opcode      = s_q.bad_op;
  assign mem_addr            = s_q.addr;
  assign mem_rd              = s_q.mem_rd;
  assign mem_we              = s_q.mem_we;
  assign mem_wdata           = s_q.wdata;
  assign acc_out             = s_q.acc;
  assign borrow_flag         = s_q.c;
  assign nibble_borrow_flag  = s_q.nb;
  assign zero_flag           = s_q.z;
  assign tmr_prescaler_clear = s_q.tmr_clr;
  assign tmr_count_hold      = s_q.tmr_hold;
  assign prdata              = s_q.prdata;
  assign pready              = s_q.pready;
  assign pslverr             = s_q.pslverr;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_accept;
    instr_valid && instr_ready;
  endsequence

  sequence s_exec(bax_op_type k);
    s_q.st == BAX_EXEC && s_q.op == k;
  endsequence

  a_fetch_addr: assert property (s_accept |=> mem_rd && !instr_ready // RULE16
    && mem_addr == $past(opcode[8:0]))
    else $error("address not taken from opcode");

  a_one_instr: assert property (s_accept |-> ##2 (s_q.st == BAX_EXEC) ##1 instr_done) // RULE15
    else $error("instruction did not complete in time");

  a_subc_result: assert property (s_exec(BAX_OP_SUBC_W) |=> !mem_we // RULE1
    && acc_out == 8'($past(register_operand) - $past(acc_out) - {7'h00, ~$past(borrow_flag)}))
    else $error("subtract result wrong");

  a_subc_borrow: assert property (s_exec(BAX_OP_SUBC_W) |=> borrow_flag == // RULE3
    ({1'b0, $past(register_operand)} >= ({1'b0, $past(acc_out)} + {8'h00, ~$past(borrow_flag)})))
    else $error("borrow flag wrong");

  a_subc_nibble: assert property (s_exec(BAX_OP_SUBC_W) |=> nibble_borrow_flag == // RULE4
    ({1'b0, $past(register_operand[3:0])} >=
     ({1'b0, $past(acc_out[3:0])} + {4'h0, ~$past(borrow_flag)})))
    else $error("nibble borrow flag wrong");

  a_subc_zero: assert property (s_exec(BAX_OP_SUBC_W) |=> zero_flag == (acc_out == 8'h00)) // RULE5
    else $error("zero flag wrong after subtract");

  a_swap_mem: assert property (s_exec(BAX_OP_SWAP_F) |=> mem_we && $stable(acc_out) // RULE6
    && mem_wdata == {$past(register_operand[3:0]), $past(register_operand[7:4])}
    && $stable(zero_flag) && $stable(borrow_flag) && $stable(nibble_borrow_flag))
    else $error("in-place swap wrong");

  a_swap_acc: assert property (s_exec(BAX_OP_SWAP_W) |=> !mem_we && $stable(zero_flag) // RULE7
    && acc_out == {$past(register_operand[3:0]), $past(register_operand[7:4])})
    else $error("accumulator swap wrong");

  a_test_reg: assert property (s_exec(BAX_OP_TEST_F) |=> mem_we // RULE8
    && mem_wdata == $past(register_operand) && $stable(borrow_flag)
    && zero_flag == ($past(register_operand) == 8'h00))
    else $error("register test wrong");

  a_test_timer: assert property ((s_exec(BAX_OP_TEST_F) and s_q.addr == s_q.tmr_addr) // RULE9
    |=> tmr_prescaler_clear && tmr_count_hold ##1 !tmr_prescaler_clear) // RULE10
    else $error("timer prescaler not cleared");

  a_xor_mem: assert property (s_exec(BAX_OP_XOR_F) |=> mem_we && $stable(acc_out) // RULE11
    && mem_wdata == ($past(register_operand) ^ $past(acc_out)))
    else $error("register xor wrong");

  a_xor_acc: assert property (s_exec(BAX_OP_XOR_W) |=> !mem_we // RULE12
    && acc_out == ($past(register_operand) ^ $past(acc_out)))
    else $error("accumulator xor wrong");

  a_xor_imm: assert property (s_exec(BAX_OP_XOR_K) |=> // RULE13
    acc_out == ($past(s_q.imm) ^ $past(acc_out)))
    else $error("immediate xor wrong");

  a_xor_zero: assert property (s_exec(BAX_OP_XOR_W) or s_exec(BAX_OP_XOR_K) // RULE14
    |=> zero_flag == (acc_out == 8'h00) && $stable(borrow_flag))
    else $error("xor zero flag wrong");

  a_xor_mem_zero: assert property (s_exec(BAX_OP_XOR_F) |=> // RULE14
    zero_flag == (mem_wdata == 8'h00) && $stable(borrow_flag))
    else $error("register xor zero flag wrong");

  a_test_quiet: assert property ((s_exec(BAX_OP_TEST_F) and s_q.addr != s_q.tmr_addr) // RULE9
    |=> !tmr_prescaler_clear && !tmr_count_hold)
    else $error("timer prescaler cleared for another address");

  a_illegal_quiet: assert property (s_exec(BAX_OP_NONE) |=> illegal_opcode && !mem_we
    && $stable(acc_out) && $stable(zero_flag) && $stable(borrow_flag))
    else $error("foreign opcode changed state");

  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("register slave wait state wrong");

endmodule

`default_nettype wire

// >>> verilog/bax_pkg.sv
package bax_pkg;

  // ==========================================================================
  // Opcode patterns.
  localparam logic [6:0]  BAX_PAT_SUBC_W = 7'h24;
  localparam logic [6:0]  BAX_PAT_SWAP_F = 7'h1d;
  localparam logic [6:0]  BAX_PAT_SWAP_W = 7'h1c;
  localparam logic [6:0]  BAX_PAT_TEST_F = 7'h11;
  localparam logic [6:0]  BAX_PAT_XOR_F  = 7'h0d;
  localparam logic [6:0]  BAX_PAT_XOR_W  = 7'h0c;
  localparam logic [7:0]  BAX_PAT_XOR_K  = 8'h7f;
  localparam int          BAX_PAT_LSB    = 9;
  localparam int          BAX_ADDR_W     = 9;

  // ==========================================================================
  // Register map of the control slave.
  localparam logic [11:0] BAX_OFF_CTRL   = 12'h000;
  localparam logic [11:0] BAX_OFF_STATE  = 12'h004;
  localparam logic [11:0] BAX_OFF_COUNT  = 12'h008;
  localparam int          BAX_CTRL_EN    = 0;
  localparam int          BAX_CTRL_TA    = 16;
  localparam int          BAX_STATE_C    = 8;
  localparam int          BAX_STATE_NB   = 9;
  localparam int          BAX_STATE_Z    = 10;
  localparam int          BAX_STATE_BUSY = 11;
  localparam logic        BAX_RST_EN     = 1'b1;
  localparam logic [8:0]  BAX_RST_TADDR  = 9'h001;
  localparam logic [7:0]  BAX_RST_ACC    = 8'h00;

  // ==========================================================================
  // Sequencer states and operation classes.
  typedef enum logic [2:0] {
    BAX_IDLE  = 3'h1,
    BAX_FETCH = 3'h2,
    BAX_EXEC  = 3'h4
  } bax_state_type;

  typedef enum logic [2:0] {
    BAX_OP_NONE   = 3'h0,
    BAX_OP_SUBC_W = 3'h1,
    BAX_OP_SWAP_F = 3'h2,
    BAX_OP_SWAP_W = 3'h3,
    BAX_OP_TEST_F = 3'h4,
    BAX_OP_XOR_F  = 3'h5,
    BAX_OP_XOR_W  = 3'h6,
    BAX_OP_XOR_K  = 3'h7
  } bax_op_type;

  // Maps an instruction word onto the operation class of this group.
  function automatic bax_op_type bax_decode(input logic [15:0] op);
    bax_op_type k;
    k = BAX_OP_NONE;
    if (op[15:8] == BAX_PAT_XOR_K) begin
      k = BAX_OP_XOR_K;
    end else if (op[15:BAX_PAT_LSB] == BAX_PAT_SUBC_W) begin
      k = BAX_OP_SUBC_W;
    end else if (op[15:BAX_PAT_LSB] == BAX_PAT_SWAP_F) begin
      k = BAX_OP_SWAP_F;
    end else if (op[15:BAX_PAT_LSB] == BAX_PAT_SWAP_W) begin
      k = BAX_OP_SWAP_W;
    end else if (op[15:BAX_PAT_LSB] == BAX_PAT_TEST_F) begin
      k = BAX_OP_TEST_F;
    end else if (op[15:BAX_PAT_LSB] == BAX_PAT_XOR_F) begin
      k = BAX_OP_XOR_F;
    end else if (op[15:BAX_PAT_LSB] == BAX_PAT_XOR_W) begin
      k = BAX_OP_XOR_W;
    end
    return k;
  endfunction

endpackage
